// >>> include/ufc_pkg.sv
// Package with register map, field positions and timing constants for the flow-control UART
// Overview of operation
// - Break holds TX low thirteen bit periods
// - Seven or eight bit characters use one byte
// - Nine bit characters use two bytes, little-endian
// - RTS and CTS used only when enabled
// - RTS active low, CTS active low, pulled up
// - CTS deasserted stalls start of new characters
// - Buffer transmit times out, reports bytes accepted
// - After timeout one character stays pending
// - Single write fails with code 116 on timeout while stalled by CTS
// - Full buffer plus arrival deasserts RTS
// - Reads from buffer reassert RTS
// - Overflow character excluded from count, moved later
// - Zero-length buffer deasserts RTS per character
// - Seven to nine bits, parity, one or two stops
package ufc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BAUD = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_RXDATA = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_TIMEOUT = 8'h14;
	localparam logic [7:0] OFS_TXCOUNT = 8'h18;
	localparam logic [7:0] OFS_RXCFG = 8'h1c;
	// Control field positions
	localparam int CTRL_BITS_LO = 0;
	localparam int CTRL_PAR_EN = 2;
	localparam int CTRL_PAR_ODD = 3;
	localparam int CTRL_STOP2 = 4;
	localparam int CTRL_RTS_EN = 5;
	localparam int CTRL_CTS_EN = 6;
	localparam int CTRL_BREAK = 7;
	localparam int CTRL_TXCLR = 8;
	// Character width codes
	localparam logic [1:0] BITS_7 = 2'h0;
	localparam logic [1:0] BITS_8 = 2'h1;
	localparam logic [1:0] BITS_9 = 2'h2;
	// Reset values
	localparam logic [8:0] CTRL_RST = 9'h001;
	localparam logic [15:0] BAUD_RST = 16'h06c8;
	localparam logic [31:0] TIMEOUT_RST = 32'h00030d40;
	localparam logic [4:0] RXLEN_RST = 5'h10;
	// Status field positions
	localparam int ST_TXBUSY = 0;
	localparam int ST_TIMEOUT = 1;
	localparam int ST_RTS_HELD = 2;
	localparam int ST_PENDING = 3;
	localparam int ST_CTS = 4;
	localparam int ST_ERRCODE_LO = 8;
	localparam int ST_RXCOUNT_LO = 16;
	// Error code for a timed-out single write
	localparam logic [7:0] ERR_TIMEDOUT = 8'h74;
	// Break length in bit periods
	localparam logic [3:0] BREAK_BITS = 4'hd;
	// Receive buffer depth
	localparam int RX_DEPTH = 16;
	localparam int RX_AW = 4;
	// Transmit engine states, Gray along the main path
	typedef enum logic [2:0] {
		TXS_IDLE = 3'h0,
		TXS_START = 3'h1,
		TXS_DATA = 3'h3,
		TXS_PAR = 3'h2,
		TXS_STOP = 3'h6,
		TXS_BRK = 3'h7
	} ufc_tx_state_t;
	// Receive engine states
	typedef enum logic [2:0] {
		RXS_IDLE = 3'h0,
		RXS_START = 3'h1,
		RXS_DATA = 3'h3,
		RXS_PAR = 3'h2,
		RXS_STOP = 3'h6
	} ufc_rx_state_t;
endpackage : ufc_pkg

// >>> verilog/ufc_mem.sv
// Receive character storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module ufc_mem (
	input wire logic ref_clk, // Clock
	input wire logic we, // Write enable
	input wire logic [3:0] waddr, // Write address
	input wire logic [8:0] wdata, // Write data
	input wire logic [3:0] raddr, // Read address
	output logic [8:0] rdata // Registered read data
);
	logic [8:0] mem [0:15]; // Storage array

	// Write port
	always_ff @(posedge ref_clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read port
	always_ff @(posedge ref_clk)
	begin
		rdata <= mem[raddr];
	end
endmodule : ufc_mem
`default_nettype wire

// >>> verilog/ufc_skid.sv
// Two-entry valid/ready buffer for transmit characters
`timescale 1ns/1ps
`default_nettype none
module ufc_skid (
	input wire logic ref_clk, // Clock
	input wire logic arst_n, // Async reset, active low
	input wire logic clr, // Discard contents
	input wire logic in_valid, // Source has a word
	output logic in_ready, // Room for a word
	input wire logic [8:0] in_data, // Word in
	output logic out_valid, // Word available
	input wire logic out_ready, // Sink takes word
	output logic [8:0] out_data // Word out
);
	logic [8:0] slot0; // Head entry
	logic [8:0] slot1; // Second entry
	logic [1:0] cnt; // Entries held
	logic push; // Word accepted
	logic pop; // Word removed

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (cnt != 2'h2);
	assign out_valid = (cnt != 2'h0);
	assign out_data = slot0;

	// Entry count
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt <= 2'h0;
		else if (clr)
			cnt <= 2'h0;
		else
			cnt <= cnt + {1'b0, push} - {1'b0, pop};
	end

	// Data shifting
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			slot0 <= 9'h000;
			slot1 <= 9'h000;
		end
		else
		begin
			if (pop)
				slot0 <= (cnt == 2'h2) ? slot1 : in_data;
			else if (push && cnt == 2'h0)
				slot0 <= in_data;
			if (push && ((cnt == 2'h1 && !pop) || (cnt == 2'h2)))
				slot1 <= in_data;
		end
	end
endmodule : ufc_skid
`default_nettype wire

// >>> verilog/ufc_uart.sv
// Flow-controlled UART with APB register access
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ufc_uart (
	input wire logic ref_clk, // 200 MHz clock
	input wire logic arst_n, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic tx, // Serial out
	input wire logic rx, // Serial in
	output logic rts_n, // Request to send, active low
	input wire logic cts_n // Clear to send, active low, pulled up
);
	logic [8:0] ctrl; // Control register
	logic [15:0] baud_div; // Clocks per bit minus one
	logic [31:0] timeout; // Transmit timeout in clocks
	logic [4:0] rx_len; // Receive buffer length, 0 to 16
	logic rx_s1, rx_s2, cts_s1, cts_s2; // Pin synchronisers
	logic acc; // APB access cycle
	logic wr_acc, rd_acc; // Write or read access
	logic tx_lo_hold; // Low byte of nine-bit pair
	logic [7:0] tx_lo; // Held low byte
	logic ib_valid; // Character offered to buffer
	logic [8:0] ib_data; // Character offered
	logic ib_ready, ob_valid, ob_ready; // Buffer handshakes
	logic [8:0] ob_data; // Character leaving buffer
	logic [31:0] tx_count; // Bytes accepted this write
	logic [31:0] to_cnt; // Timeout counter
	logic to_flag; // Timeout occurred
	logic [7:0] err_code; // Last error code
	ufc_pkg::ufc_tx_state_t tx_st; // Transmit state
	logic [15:0] tx_tick; // Transmit bit timer
	logic [3:0] tx_bit; // Transmit bit index
	logic [8:0] tx_sh; // Transmit shift data
	logic tx_par; // Running transmit parity
	logic brk_req; // Break pending
	logic [3:0] nbits; // Data bits for current width
	logic cts_ok; // Transmission allowed
	ufc_pkg::ufc_rx_state_t rx_st; // Receive state
	logic [15:0] rx_tick; // Receive bit timer
	logic [3:0] rx_bit; // Receive bit index
	logic [8:0] rx_sh; // Receive shift data
	logic rx_done; // Character complete pulse
	logic [8:0] ovf_data; // Overflow hold character
	logic ovf_valid; // Overflow hold in use
	logic [3:0] wp, rp; // Buffer pointers
	logic [4:0] rx_cnt; // Characters stored
	logic [8:0] mem_rd; // Memory read data
	logic rx_hi_next; // Next read returns high byte
	logic pop; // Character removed by read
	logic mem_we; // Store a character
	logic [8:0] mem_wd; // Character stored

	assign acc = psel && penable;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	assign nbits = (ctrl[1:0] == ufc_pkg::BITS_7) ? 4'h7 :
		(ctrl[1:0] == ufc_pkg::BITS_9) ? 4'h9 : 4'h8;
	// CTS ignored unless enabled; pulled-up idle reads deasserted
	assign cts_ok = !ctrl[ufc_pkg::CTRL_CTS_EN] || !cts_s2;

	// Pin synchronisers
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			cts_s1 <= 1'b1;
			cts_s2 <= 1'b1;
		end
		else
		begin
			rx_s1 <= rx;
			rx_s2 <= rx_s1;
			cts_s1 <= cts_n;
			cts_s2 <= cts_s1;
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl <= ufc_pkg::CTRL_RST;
			baud_div <= ufc_pkg::BAUD_RST;
			timeout <= ufc_pkg::TIMEOUT_RST;
			rx_len <= ufc_pkg::RXLEN_RST;
		end
		else if (wr_acc)
		begin
			if (paddr == ufc_pkg::OFS_CTRL)
				ctrl <= {1'b0, pwdata[7:0]};
			else if (paddr == ufc_pkg::OFS_BAUD)
				baud_div <= pwdata[15:0];
			else if (paddr == ufc_pkg::OFS_TIMEOUT)
				timeout <= pwdata;
			else if (paddr == ufc_pkg::OFS_RXCFG)
				rx_len <= (pwdata[4:0] > 5'h10) ? 5'h10 : pwdata[4:0];
		end
		else
			ctrl[ufc_pkg::CTRL_BREAK] <= 1'b0;
	end

	// Transmit byte packing into characters
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_lo_hold <= 1'b0;
			tx_lo <= 8'h00;
			ib_valid <= 1'b0;
			ib_data <= 9'h000;
		end
		else
		begin
			if (ib_valid && ib_ready)
				ib_valid <= 1'b0;
			if (wr_acc && paddr == ufc_pkg::OFS_TXDATA && !ib_valid)
			begin
				if (ctrl[1:0] == ufc_pkg::BITS_9 && !tx_lo_hold)
				begin
					tx_lo_hold <= 1'b1; // Low byte first
					tx_lo <= pwdata[7:0];
				end
				else if (ctrl[1:0] == ufc_pkg::BITS_9)
				begin
					tx_lo_hold <= 1'b0;
					ib_valid <= 1'b1;
					ib_data <= {pwdata[0], tx_lo}; // High byte bit 0
				end
				else
				begin
					ib_valid <= 1'b1; // One byte per character
					ib_data <= {1'b0, pwdata[7:0]};
				end
			end
		end
	end

	// Accepted byte count and timeout
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_count <= 32'h0;
			to_cnt <= 32'h0;
			to_flag <= 1'b0;
			err_code <= 8'h00;
		end
		else if (wr_acc && paddr == ufc_pkg::OFS_CTRL && pwdata[ufc_pkg::CTRL_TXCLR])
		begin
			tx_count <= 32'h0;
			to_cnt <= 32'h0;
			// A timeout in the clearing cycle still sets the flag
			to_flag <= (ib_valid || ob_valid) && (to_cnt >= timeout);
			err_code <= ((ib_valid || ob_valid) && (to_cnt >= timeout) && !cts_ok) ?
				ufc_pkg::ERR_TIMEDOUT : 8'h00;
		end
		else
		begin
			if (wr_acc && paddr == ufc_pkg::OFS_TXDATA && !ib_valid)
				tx_count <= tx_count + 32'h1; // Pending bytes still counted
			if (ib_valid || ob_valid)
			begin
				if (to_cnt >= timeout)
				begin
					to_flag <= 1'b1; // Buffer write timed out
					if (!cts_ok)
						err_code <= ufc_pkg::ERR_TIMEDOUT; // Stalled by CTS
				end
				else
					to_cnt <= to_cnt + 32'h1;
			end
			else
				to_cnt <= 32'h0;
		end
	end

	ufc_skid u_skid (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clr(1'b0),
		.in_valid(ib_valid),
		.in_ready(ib_ready),
		.in_data(ib_data),
		.out_valid(ob_valid),
		.out_ready(ob_ready),
		.out_data(ob_data)
	);

	// Character leaves buffer only when a frame may start
	assign ob_ready = (tx_st == ufc_pkg::TXS_IDLE) && cts_ok && !brk_req;

	// Transmit engine
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_st <= ufc_pkg::TXS_IDLE;
			tx_tick <= 16'h0;
			tx_bit <= 4'h0;
			tx_sh <= 9'h000;
			tx_par <= 1'b0;
			tx <= 1'b1;
			brk_req <= 1'b0;
		end
		else
		begin
			tx_tick <= (tx_tick == 16'h0) ? 16'h0 : tx_tick - 16'h1;
			case (tx_st)
				ufc_pkg::TXS_IDLE:
				begin
					tx <= 1'b1;
					if (brk_req)
					begin
						brk_req <= 1'b0;
						tx <= 1'b0; // Break drives line low
						tx_bit <= 4'h0;
						tx_tick <= baud_div;
						tx_st <= ufc_pkg::TXS_BRK;
					end
					else if (ob_valid && ob_ready)
					begin
						tx <= 1'b0; // Start bit
						tx_sh <= ob_data;
						tx_par <= ctrl[ufc_pkg::CTRL_PAR_ODD];
						tx_bit <= 4'h0;
						tx_tick <= baud_div;
						tx_st <= ufc_pkg::TXS_START;
					end
				end
				ufc_pkg::TXS_START, ufc_pkg::TXS_DATA:
				begin
					if (tx_tick == 16'h0)
					begin
						tx_tick <= baud_div;
						if (tx_st == ufc_pkg::TXS_DATA && tx_bit == nbits)
						begin
							tx <= ctrl[ufc_pkg::CTRL_PAR_EN] ? tx_par : 1'b1;
							tx_bit <= 4'h0;
							tx_st <= ctrl[ufc_pkg::CTRL_PAR_EN] ? ufc_pkg::TXS_PAR :
								ufc_pkg::TXS_STOP;
						end
						else
						begin
							tx <= tx_sh[0]; // LSB first
							tx_par <= tx_par ^ tx_sh[0];
							tx_sh <= {1'b0, tx_sh[8:1]};
							tx_bit <= tx_bit + 4'h1;
							tx_st <= ufc_pkg::TXS_DATA;
						end
					end
				end
				ufc_pkg::TXS_PAR:
				begin
					if (tx_tick == 16'h0)
					begin
						tx <= 1'b1;
						tx_tick <= baud_div;
						tx_st <= ufc_pkg::TXS_STOP;
					end
				end
				ufc_pkg::TXS_STOP:
				begin
					if (tx_tick == 16'h0)
					begin
						tx_tick <= baud_div;
						tx_bit <= tx_bit + 4'h1;
						if (tx_bit == {3'h0, ctrl[ufc_pkg::CTRL_STOP2]}) // One or two stops
							tx_st <= ufc_pkg::TXS_IDLE;
					end
				end
				ufc_pkg::TXS_BRK:
				begin
					if (tx_tick == 16'h0)
					begin
						tx_tick <= baud_div;
						tx_bit <= tx_bit + 4'h1;
						if (tx_bit == ufc_pkg::BREAK_BITS - 4'h1)
						begin
							tx <= 1'b1; // Back to idle after thirteen bits
							tx_st <= ufc_pkg::TXS_STOP;
							tx_bit <= 4'h0;
						end
					end
				end
				default:
					tx_st <= ufc_pkg::TXS_IDLE;
			endcase
			// New break request wins over the clear of an old one
			if (wr_acc && paddr == ufc_pkg::OFS_CTRL && pwdata[ufc_pkg::CTRL_BREAK])
				brk_req <= 1'b1;
		end
	end

	// Receive engine, samples mid-bit
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_st <= ufc_pkg::RXS_IDLE;
			rx_tick <= 16'h0;
			rx_bit <= 4'h0;
			rx_sh <= 9'h000;
			rx_done <= 1'b0;
		end
		else
		begin
			rx_done <= 1'b0;
			rx_tick <= (rx_tick == 16'h0) ? 16'h0 : rx_tick - 16'h1;
			case (rx_st)
				ufc_pkg::RXS_IDLE:
				begin
					if (!rx_s2)
					begin
						rx_tick <= {1'b0, baud_div[15:1]};
						rx_st <= ufc_pkg::RXS_START;
					end
				end
				ufc_pkg::RXS_START:
				begin
					if (rx_tick == 16'h0)
					begin
						rx_tick <= baud_div;
						rx_bit <= 4'h0;
						rx_sh <= 9'h000;
						rx_st <= rx_s2 ? ufc_pkg::RXS_IDLE : ufc_pkg::RXS_DATA;
					end
				end
				ufc_pkg::RXS_DATA:
				begin
					if (rx_tick == 16'h0)
					begin
						rx_tick <= baud_div;
						rx_sh[rx_bit] <= rx_s2;
						rx_bit <= rx_bit + 4'h1;
						if (rx_bit == nbits - 4'h1)
							rx_st <= ctrl[ufc_pkg::CTRL_PAR_EN] ? ufc_pkg::RXS_PAR :
								ufc_pkg::RXS_STOP;
					end
				end
				ufc_pkg::RXS_PAR:
				begin
					if (rx_tick == 16'h0)
					begin
						rx_tick <= baud_div;
						rx_st <= ufc_pkg::RXS_STOP;
					end
				end
				ufc_pkg::RXS_STOP:
				begin
					if (rx_tick == 16'h0)
					begin
						rx_done <= rx_s2;
						rx_st <= ufc_pkg::RXS_IDLE;
					end
				end
				default:
					rx_st <= ufc_pkg::RXS_IDLE;
			endcase
		end
	end

	// Read of a whole character pops it; nine-bit needs the high byte read
	assign pop = rd_acc && paddr == ufc_pkg::OFS_RXDATA && rx_cnt != 5'h0 &&
		(ctrl[1:0] != ufc_pkg::BITS_9 || rx_hi_next);
	// Store new character, or overflow hold once space frees
	assign mem_we = (rx_cnt < rx_len || (pop && rx_cnt == rx_len)) && (ovf_valid || rx_done);
	assign mem_wd = ovf_valid ? ovf_data : rx_sh;

	ufc_mem u_mem (
		.ref_clk(ref_clk),
		.we(mem_we),
		.waddr(wp),
		.wdata(mem_wd),
		.raddr(pop ? rp + 4'h1 : rp),
		.rdata(mem_rd)
	);

	// Receive buffer, overflow hold and RTS
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wp <= 4'h0;
			rp <= 4'h0;
			rx_cnt <= 5'h0;
			ovf_valid <= 1'b0;
			ovf_data <= 9'h000;
			rx_hi_next <= 1'b0;
			rts_n <= 1'b1;
		end
		else
		begin
			if (mem_we)
				wp <= wp + 4'h1;
			if (pop)
				rp <= rp + 4'h1;
			rx_cnt <= rx_cnt + {4'h0, mem_we} - {4'h0, pop};
			if (ovf_valid && mem_we)
				ovf_valid <= rx_done; // New arrival takes the freed hold
			// Read of the held character with no buffer frees the hold
			if (rd_acc && paddr == ufc_pkg::OFS_RXDATA && rx_cnt == 5'h0 && !mem_we &&
				(ctrl[1:0] != ufc_pkg::BITS_9 || rx_hi_next))
				ovf_valid <= 1'b0;
			if (rx_done && !(mem_we && !ovf_valid))
			begin
				ovf_valid <= 1'b1; // Held, not counted
				ovf_data <= rx_sh;
			end
			if (rd_acc && paddr == ufc_pkg::OFS_RXDATA && ctrl[1:0] == ufc_pkg::BITS_9 &&
				(rx_cnt != 5'h0 || ovf_valid))
				rx_hi_next <= !rx_hi_next;
			if (!ctrl[ufc_pkg::CTRL_RTS_EN])
				rts_n <= 1'b0; // Not driven as handshake when disabled
			else if (rx_done && (rx_cnt == rx_len || ovf_valid))
				rts_n <= 1'b1; // Arrival into full buffer deasserts
			else if (pop || (rx_len == 5'h0 && rd_acc && paddr == ufc_pkg::OFS_RXDATA))
				rts_n <= 1'b0; // Reads reassert
		end
	end

	// Zero-length buffer: overflow hold is the only storage, freed by read
	// APB slave, zero wait states
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable)
			begin
				if (paddr == ufc_pkg::OFS_CTRL)
					prdata <= {23'h0, ctrl};
				else if (paddr == ufc_pkg::OFS_BAUD)
					prdata <= {16'h0, baud_div};
				else if (paddr == ufc_pkg::OFS_RXDATA)
					prdata <= (rx_cnt == 5'h0) ? {23'h0, ovf_data} :
						rx_hi_next ? {31'h0, mem_rd[8]} : {24'h0, mem_rd[7:0]};
				else if (paddr == ufc_pkg::OFS_STATUS)
					prdata <= {11'h0, rx_cnt, err_code, 3'h0, !cts_s2, ob_valid,
						rts_n, to_flag, tx_st != ufc_pkg::TXS_IDLE};
				else if (paddr == ufc_pkg::OFS_TIMEOUT)
					prdata <= timeout;
				else if (paddr == ufc_pkg::OFS_TXCOUNT)
					prdata <= tx_count;
				else if (paddr == ufc_pkg::OFS_RXCFG)
					prdata <= {27'h0, rx_len};
				else if (paddr != ufc_pkg::OFS_TXDATA)
					pslverr <= 1'b1; // Unmapped address
			end
		end
	end
endmodule : ufc_uart
`default_nettype wire

// >>> tb/ufc_monitor.sv
// Checker for APB answer timing and serial bit timing of the UART
`timescale 1ns/1ps
`default_nettype none
module ufc_monitor (
	input wire logic ref_clk, // Clock
	input wire logic arst_n, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic tx, // Serial out
	input wire logic rx, // Serial in
	input wire logic rts_n, // RTS, active low
	input wire logic cts_n // CTS, active low
);
	logic [8:0] low_cnt; // Samples of tx low in a row, saturating
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	// Length of the current low run on tx
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			low_cnt <= 9'h000;
		else
			low_cnt <= tx ? 9'h000 : low_cnt + {8'h00, low_cnt != 9'h1ff};
	// Setup answered by one ready, gone after it
	property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
	// Ready only inside an access phase
	property p_acc; pready |-> psel && penable; endproperty
	a_acc: assert property (p_acc) else $error("ready outside access");
	// Error for addresses past the map
	property p_unm; pready && (paddr > 8'h1c) |-> pslverr; endproperty
	a_unm: assert property (p_unm) else $error("no error on unmapped address");
	// No error inside the map
	property p_map; pready && (paddr <= 8'h1c) && (paddr[1:0] == 2'h0) |-> !pslverr; endproperty
	a_map: assert property (p_map) else $error("error on mapped address");
	// Counter clear bit always reads zero
	property p_clr; pready && !pwrite && (paddr == ufc_pkg::OFS_CTRL) |-> !prdata[8]; endproperty
	a_clr: assert property (p_clr) else $error("clear bit read back");
	// Every low level lasts at least one bit of eight clocks
	property p_low; $fell(tx) |-> !tx [*8]; endproperty
	a_low: assert property (p_low) else $error("short low bit");
	// Every high level lasts at least one bit
	property p_high; $rose(tx) |-> tx [*8]; endproperty
	a_high: assert property (p_high) else $error("short high bit");
	// No low run beyond thirteen bits
	property p_brk; low_cnt <= 9'h068; endproperty
	a_brk: assert property (p_brk) else $error("break too long");
endmodule : ufc_monitor
`default_nettype wire

// >>> tb/ufc_target.sv
// Serial target model with RTS/CTS handshake
`timescale 1ns/1ps
`default_nettype none
module ufc_target #(
	parameter int BIT = 8 // Clocks per bit
) (
	input wire logic ref_clk, // Clock
	input wire logic tx, // Device serial out
	input wire logic rts_n, // Device RTS, active low
	output logic rx, // Device serial in
	output logic cts_n // Device CTS, active low
);
	logic hold_n; // Own RTS, low lets the device send
	// Own RTS wired to the device CTS
	assign cts_n = hold_n;
	// Line idle high, device held off at start
	initial
	begin
		rx = 1'b1;
		hold_n = 1'b1;
	end
	// One 8N1 character, only while device RTS is low
	task automatic send(input logic [7:0] c, output logic ok);
		int i;
		for (i = 0; i < 2000 && rts_n !== 1'b0; i++)
			@(posedge ref_clk);
		ok = (rts_n === 1'b0);
		for (i = 0; ok && i < 10; i++)
		begin
			rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i - 1];
			repeat (BIT) @(posedge ref_clk);
		end
	endtask : send
	// Capture n bits after a start bit, mid-bit samples
	task automatic get(input int n, output logic [11:0] w);
		int i;
		w = 12'hfff;
		for (i = 0; i < 3000 && tx !== 1'b0; i++)
			@(posedge ref_clk);
		repeat (BIT / 2) @(posedge ref_clk);
		for (i = 0; i < n; i++)
		begin
			repeat (BIT) @(posedge ref_clk);
			w[i] = tx;
		end
	endtask : get
	// Length of the next low run in clocks
	task automatic brk(output int n);
		int i;
		n = 0;
		for (i = 0; i < 3000 && tx !== 1'b0; i++)
			@(posedge ref_clk);
		for (i = 0; i < 300 && tx === 1'b0; i++)
		begin
			@(posedge ref_clk);
			n++;
		end
	endtask : brk
endmodule : ufc_target
`default_nettype wire

// >>> tb/testbench.sv
// Testbench for the flow-controlled UART
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int BIT = 8; // Clocks per bit with BAUD of seven
	logic ref_clk = 1'b0; // Clock
	logic arst_n = 1'b0; // Reset, active low
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB control
	logic [7:0] paddr = 8'h00; // APB address
	logic [31:0] pwdata = 32'h0, prdata, rv; // APB data, last read
	logic pready, pslverr, slv, tx, rx, rts_n, cts_n, ok; // Flags and lines
	logic [11:0] w; // Captured frame
	int err_total = 0, n_checks = 0, i, n; // Counters
	logic [8:0] ctl [4] = '{9'h001, 9'h004, 9'h01d, 9'h002}; // 8N1 7E1 8O2 9N1
	logic [8:0] dat [4] = '{9'h0c3, 9'h037, 9'h081, 9'h1a5}; // Characters
	int nb [4] = '{10, 9, 11, 10}; // Bits after start
	logic [11:0] fr [4] = '{12'hfc3, 12'hfb7, 12'hf81, 12'hfa5}; // Expected frames
	ufc_uart uut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .tx, .rx, .rts_n, .cts_n);
	ufc_target #(.BIT(BIT)) t (.ref_clk, .tx, .rts_n, .rx, .cts_n);
	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	// Compare one value
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// One APB transfer, held until ready
	task automatic xfer(input logic dir, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= dir;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge ref_clk);
		rv = prdata;
		slv = pslverr;
		if (pready !== 1'b1)
			chk(pready, 1'b1);
		if (pready !== 1'b1)
			complete_run();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask : rd
	// Bounded wait for a level on RTS
	task automatic wait_rts(input logic v);
		int k;
		for (k = 0; k < 200 && rts_n !== v; k++)
			@(posedge ref_clk);
		chk(rts_n, v);
		if (rts_n !== v)
			complete_run();
	endtask : wait_rts
	// Free-running clock
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Main sequence
	initial
	begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		rd(ufc_pkg::OFS_CTRL);
		chk(rv, {23'h0, ufc_pkg::CTRL_RST});
		rd(ufc_pkg::OFS_BAUD);
		chk(rv, {16'h0, ufc_pkg::BAUD_RST});
		rd(ufc_pkg::OFS_RXCFG);
		chk(rv, {27'h0, ufc_pkg::RXLEN_RST});
		rd(8'h20);
		chk(slv, 1'b1);
		chk(rts_n, 1'b0);
		wr(ufc_pkg::OFS_BAUD, 32'h7);
		wr(ufc_pkg::OFS_TIMEOUT, 32'h3e8);
		// Every width and parity, CTS ignored while disabled
		for (i = 0; i < 4; i++)
		begin
			wr(ufc_pkg::OFS_CTRL, {23'h0, ctl[i]});
			wr(ufc_pkg::OFS_TXDATA, {24'h0, dat[i][7:0]});
			if (ctl[i][1])
				wr(ufc_pkg::OFS_TXDATA, {31'h0, dat[i][8]});
			t.get(nb[i], w);
			chk({20'h0, w}, {20'h0, fr[i]});
			repeat (2 * BIT) @(posedge ref_clk);
		end
		rd(ufc_pkg::OFS_TXCOUNT);
		chk(rv, 32'h5);
		wr(ufc_pkg::OFS_CTRL, 32'h81);
		t.brk(n);
		chk(n, 13 * BIT);
		// Held by CTS past the timeout, sent once released
		wr(ufc_pkg::OFS_CTRL, 32'h141);
		wr(ufc_pkg::OFS_TXDATA, 32'h3c);
		repeat (1200) @(posedge ref_clk);
		rd(ufc_pkg::OFS_STATUS);
		chk(rv[ufc_pkg::ST_TIMEOUT], 1'b1);
		chk(rv[ufc_pkg::ST_PENDING], 1'b1);
		chk(rv[ufc_pkg::ST_CTS], 1'b0);
		chk({24'h0, rv[15:8]}, {24'h0, ufc_pkg::ERR_TIMEDOUT});
		rd(ufc_pkg::OFS_TXCOUNT);
		chk(rv, 32'h1);
		t.hold_n <= 1'b0;
		t.get(9, w);
		chk({20'h0, w}, 32'hf3c);
		rd(ufc_pkg::OFS_STATUS);
		chk(rv[ufc_pkg::ST_CTS], 1'b1);
		// Two-entry receive buffer plus one held character
		wr(ufc_pkg::OFS_CTRL, 32'h21);
		wr(ufc_pkg::OFS_RXCFG, 32'h2);
		for (i = 1; i < 4; i++)
		begin
			t.send(8'(i * 17), ok);
			chk(ok, 1'b1);
		end
		wait_rts(1'b1);
		rd(ufc_pkg::OFS_STATUS);
		chk(rv[ufc_pkg::ST_RTS_HELD], 1'b1);
		chk({27'h0, rv[20:16]}, 32'h2);
		for (i = 1; i < 4; i++)
		begin
			rd(ufc_pkg::OFS_RXDATA);
			chk({24'h0, rv[7:0]}, 32'(i * 17));
			if (i == 1)
				wait_rts(1'b0);
			rd(ufc_pkg::OFS_STATUS);
			chk({27'h0, rv[20:16]}, 32'(3 - i));
		end
		// No buffer: each character holds RTS off until read
		wr(ufc_pkg::OFS_RXCFG, 32'h0);
		t.send(8'h44, ok);
		chk(ok, 1'b1);
		wait_rts(1'b1);
		rd(ufc_pkg::OFS_RXDATA);
		chk({24'h0, rv[7:0]}, 32'h44);
		wait_rts(1'b0);
		// Character once read is gone: reopening the buffer stores nothing
		wr(ufc_pkg::OFS_RXCFG, 32'h2);
		rd(ufc_pkg::OFS_STATUS);
		chk({27'h0, rv[20:16]}, 32'h0);
		complete_run();
	end
endmodule : testbench
bind ufc_uart ufc_monitor mon (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .tx, .rx, .rts_n, .cts_n);
`default_nettype wire
